// ---- design/iag_pkg.sv ----
/*
 iag_pkg: shared constants and types for the i/o access gate and the
 programmed i/o bus between the processor end and a device controller end.
 assumes: one 25 MHz clock for both ends; instruction bit 0 is the msb.
*/
package iag_pkg;
   // instruction word layout, bit 0 is the most significant bit
   localparam int INSTR_W = 16;
   localparam logic [2:0] IO_PATTERN = 3'h3;
   localparam int IO_PAT_MSB = 15;
   localparam int IO_PAT_LSB = 13;
   localparam int AC_MSB = 12;
   localparam int AC_LSB = 11;
   localparam int OPC_MSB = 10;
   localparam int OPC_LSB = 8;
   localparam int FLAG_MSB = 7;
   localparam int FLAG_LSB = 6;
   localparam int DEV_MSB = 5;
   localparam int DEV_LSB = 0;
   localparam int DEV_W = 6;

   // segment base register: bit 2 selects address-load mode, bit 3 allows i/o
   localparam int SBR_W = 32;
   localparam int SBR_LEA_MODE_BIT = SBR_W - 1 - 2;
   localparam int SBR_IO_VALID_BIT = SBR_W - 1 - 3;

   // general i/o opcodes
   localparam logic [2:0] OPC_NO_XFER = 3'h0;
   localparam logic [2:0] OPC_IN_A = 3'h1;
   localparam logic [2:0] OPC_OUT_A = 3'h2;
   localparam logic [2:0] OPC_IN_B = 3'h3;
   localparam logic [2:0] OPC_OUT_B = 3'h4;
   localparam logic [2:0] OPC_IN_C = 3'h5;
   localparam logic [2:0] OPC_OUT_C = 3'h6;
   localparam logic [2:0] OPC_SKIP = 3'h7;

   // flag controls (f) and flag tests (t)
   localparam logic [1:0] FLAG_NONE = 2'h0;
   localparam logic [1:0] FLAG_START = 2'h1;
   localparam logic [1:0] FLAG_CLEAR = 2'h2;
   localparam logic [1:0] FLAG_PULSE = 2'h3;
   localparam logic [1:0] TEST_BUSY_SET = 2'h0;
   localparam logic [1:0] TEST_BUSY_ZERO = 2'h1;
   localparam logic [1:0] TEST_DONE_SET = 2'h2;
   localparam logic [1:0] TEST_DONE_ZERO = 2'h3;

   localparam int DATA_W = 16;
   localparam logic [15:0] DATA_ZERO = 16'h0000;

   // unanswered bus request gives up after this long (longest time, rounds down)
   localparam int CLK_MHZ = 25;
   localparam int IO_TIMEOUT_NS = 2000;
   localparam int IO_TIMEOUT_CYC = IO_TIMEOUT_NS * CLK_MHZ / 1000;
   localparam int TCNT_W = 7;

   // decode verdict of the gate
   typedef enum logic [2:0] {
      IAG_V_NONE = 3'h0,
      IAG_V_IO_EXEC = 3'h1,
      IAG_V_LEA = 3'h2,
      IAG_V_EXT_LEA = 3'h3,
      IAG_V_PROT_FAULT = 3'h4
   } iag_verdict_t;

   // direction decoding of a general i/o opcode, whichever buffer it names
   function automatic logic iag_is_output(input logic [2:0] opc);
      iag_is_output = (opc == OPC_OUT_A) || (opc == OPC_OUT_B) || (opc == OPC_OUT_C);
   endfunction

   function automatic logic iag_is_input(input logic [2:0] opc);
      iag_is_input = (opc == OPC_IN_A) || (opc == OPC_IN_B) || (opc == OPC_IN_C);
   endfunction
endpackage

// ---- design/iag_io_if.sv ----
/*
 iag_io_if: the shared programmed i/o bus between the processor end and
 device controller ends.
 assumes: both ends on one clock; a single device end answers per code.
*/
`timescale 1ns/100ps
`default_nettype none
interface iag_io_if;
   import iag_pkg::*;
   logic req;
   logic out_dir;
   logic [5:0] dev_code;
   logic [2:0] io_func;
   logic [1:0] flag_ctl;
   logic two_byte;
   logic [15:0] wdata;
   logic ack;
   logic [15:0] rdata;
   logic cond;

   modport cpu (
      output req, out_dir, dev_code, io_func, flag_ctl, two_byte, wdata,
      input ack, rdata, cond
   );
   modport dev (
      input req, out_dir, dev_code, io_func, flag_ctl, two_byte, wdata,
      output ack, rdata, cond
   );
endinterface
`default_nettype wire

// ---- design/iag_dev_end.sv ----
/*
 iag_dev_end: device controller end of the programmed i/o bus, with three
 data buffers and busy/done flags.
 assumes: processor end holds req until ack; user side on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
module iag_dev_end
   import iag_pkg::*;
#(
   parameter logic [5:0] MY_CODE = 6'h10
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   iag_io_if.dev bus,
   input wire logic [15:0] in_a,
   input wire logic [15:0] in_b,
   input wire logic [15:0] in_c,
   input wire logic finish,
   output logic [15:0] buf_a,
   output logic [15:0] buf_b,
   output logic [15:0] buf_c,
   output logic busy,
   output logic done,
   output logic start,
   output logic special
);
   typedef struct packed {
      logic ack;
      logic [15:0] rdata;
      logic cond;
      logic [15:0] buf_a;
      logic [15:0] buf_b;
      logic [15:0] buf_c;
      logic busy;
      logic done;
      logic start;
      logic special;
   } iag_dev_state_t;

   iag_dev_state_t s;
   iag_dev_state_t next_s;
   logic [15:0] wval;
   logic [15:0] rsel;
   logic hit;

   // one byte moves only the low byte, upper byte reads as zero
   always_comb begin
      wval = bus.two_byte ? bus.wdata : {8'h00, bus.wdata[7:0]};
      case (bus.io_func)
         OPC_IN_A: rsel = in_a;
         OPC_IN_B: rsel = in_b;
         OPC_IN_C: rsel = in_c;
         default: rsel = DATA_ZERO;
      endcase
      if (!bus.two_byte) begin
         rsel[15:8] = 8'h00;
      end
      // one answer per request: no re-ack while the processor drops req
      hit = bus.req && !s.ack && (bus.dev_code == MY_CODE);
   end

   // bus answer, buffers and flags
   always_comb begin
      next_s = s;
      next_s.ack = hit;
      next_s.start = 1'b0;
      next_s.special = 1'b0;
      if (hit) begin
         next_s.rdata = iag_is_input(bus.io_func) ? rsel : DATA_ZERO;
         next_s.cond = 1'b0;
         if (bus.out_dir) begin
            case (bus.io_func)
               OPC_OUT_A: next_s.buf_a = wval;
               OPC_OUT_B: next_s.buf_b = wval;
               OPC_OUT_C: next_s.buf_c = wval;
               default: next_s.buf_a = s.buf_a;
            endcase
         end
         if (bus.io_func == OPC_SKIP) begin
            case (bus.flag_ctl)
               TEST_BUSY_SET: next_s.cond = s.busy;
               TEST_BUSY_ZERO: next_s.cond = !s.busy;
               TEST_DONE_SET: next_s.cond = s.done;
               default: next_s.cond = !s.done;
            endcase
         end else begin
            // setup of channel transfers comes through these flag controls
            case (bus.flag_ctl)
               FLAG_START: begin
                  next_s.busy = 1'b1;
                  next_s.done = 1'b0;
                  next_s.start = 1'b1;
               end
               FLAG_CLEAR: begin
                  next_s.busy = 1'b0;
                  next_s.done = 1'b0;
               end
               FLAG_PULSE: next_s.special = 1'b1;
               default: next_s.special = 1'b0;
            endcase
         end
      end
      // completion from the controller wins over a clear in the same cycle
      if (finish) begin
         next_s.busy = 1'b0;
         next_s.done = 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s <= '0;
      end else if (ce) begin
         s <= next_s;
      end
   end

   assign bus.ack = s.ack;
   assign bus.rdata = s.rdata;
   assign bus.cond = s.cond;
   assign buf_a = s.buf_a;
   assign buf_b = s.buf_b;
   assign buf_c = s.buf_c;
   assign busy = s.busy;
   assign done = s.done;
   assign start = s.start;
   assign special = s.special;
endmodule // iag_dev_end
`default_nettype wire

// ---- design/iag_cpu_end.sv ----
/*
 iag_cpu_end: processor-side i/o access gate. decides how an i/o or
 address-load opcode is treated and runs the programmed i/o transfer.
 assumes: upstream decode flags the address-load opcodes; segment base
 of the running segment is presented with the instruction; one clock.
*/
//Overview of operation
// - translation off: ignore segment base, run i/o
// - translation on: check current segment base first
// - base bit 2 set: decode as address load
// - base bit 2 clear: decode as i/o
// - only basic address load is reinterpreted
// - base bit 3 set: i/o may execute
// - base bit 3 clear: protection violation
// - one operation at a time per bus
// - transfer moves one or two bytes
// - direction named from the computer side
// - bus used only by i/o instructions, setup
// - word channel moves blocks on its own
// - i/o recognised by 011 in bits 0-2
// - bits 10-15 select one of 64 devices
`timescale 1ns/100ps
`default_nettype none
module iag_cpu_end
   import iag_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic issue,
   input wire logic [15:0] instr,
   input wire logic is_lea_op,
   input wire logic is_ext_lea_op,
   input wire logic xlat_en,
   input wire logic [31:0] seg_base,
   input wire logic [15:0] acc_in,
   input wire logic two_byte,
   iag_io_if.cpu bus,
   output logic busy,
   output logic done,
   output iag_verdict_t verdict,
   output logic fault,
   output logic [15:0] acc_out,
   output logic skip,
   output logic timeout
);
   // one-hot sequencer: idle takes an issue, wait holds the bus request
   typedef enum logic [1:0] {
      IAG_S_IDLE = 2'b01,
      IAG_S_WAIT = 2'b10
   } iag_cpu_fsm_t;

   // every register of this end in one word; the bus outputs are fields
   // of it, so nothing combinational ever reaches a pin
   typedef struct packed {
      iag_cpu_fsm_t state;
      logic req;
      logic out_dir;
      logic [5:0] dev_code;
      logic [2:0] io_func;
      logic [1:0] flag_ctl;
      logic two_byte;
      logic [15:0] wdata;
      logic busy;
      logic done;
      iag_verdict_t verdict;
      logic fault;
      logic [15:0] acc_out;
      logic skip;
      logic timeout;
      logic [TCNT_W-1:0] tcount;
   } iag_cpu_state_t;

   iag_cpu_state_t s;
   iag_cpu_state_t next_s;
   logic io_pattern;
   logic candidate;
   iag_verdict_t decided;

   // the gate decision itself, purely from the opcode, the translation enable and the segment base;
   // extended forms are tested first so the mode bit can never reach them,
   // and the valid bit matters only in i/o mode, as an address load needs no i/o right
   always_comb begin
      io_pattern = (instr[IO_PAT_MSB:IO_PAT_LSB] == IO_PATTERN);
      // a basic address load shares the i/o treatment only while translation is on
      candidate = io_pattern || is_lea_op;
      // anything that is neither i/o nor address load is not this gate's business
      decided = IAG_V_NONE;
      if (is_ext_lea_op) begin
         // extended, short and long forms never follow the mode bit
         decided = IAG_V_EXT_LEA;
      end else if (!xlat_en) begin
         // physical mode: the segment base is not looked at at all
         if (io_pattern) begin
            decided = IAG_V_IO_EXEC;
         end else if (is_lea_op) begin
            decided = IAG_V_LEA;
         end
      end else if (candidate) begin
         if (seg_base[SBR_LEA_MODE_BIT]) begin
            decided = IAG_V_LEA;
         end else if (seg_base[SBR_IO_VALID_BIT]) begin
            decided = IAG_V_IO_EXEC;
         end else begin
            decided = IAG_V_PROT_FAULT;
         end
      end
   end

   // sequencing of the programmed transfer
   always_comb begin
      next_s = s;
      next_s.done = 1'b0;
      next_s.timeout = 1'b0;
      case (s.state)
         IAG_S_IDLE: begin
            next_s.busy = 1'b0;
            // an issue while a request is pending is dropped without notice,
            // so upstream must wait for busy low before presenting the next
            if (issue) begin
               next_s.verdict = decided;
               next_s.fault = (decided == IAG_V_PROT_FAULT);
               next_s.skip = 1'b0;
               next_s.acc_out = DATA_ZERO;
               if (decided == IAG_V_IO_EXEC) begin
                  // bus driven only for an i/o instruction that may run
                  // the whole request is latched at once, so it stands
                  // unchanged on the bus until it is answered
                  next_s.req = 1'b1;
                  next_s.io_func = instr[OPC_MSB:OPC_LSB];
                  next_s.out_dir = iag_is_output(instr[OPC_MSB:OPC_LSB]);
                  next_s.dev_code = instr[DEV_MSB:DEV_LSB];
                  next_s.flag_ctl = instr[FLAG_MSB:FLAG_LSB];
                  next_s.two_byte = two_byte;
                  next_s.wdata = two_byte ? acc_in : {8'h00, acc_in[7:0]};
                  next_s.tcount = '0;
                  next_s.busy = 1'b1;
                  next_s.state = IAG_S_WAIT;
               end else begin
                  // a violation ends here: no request, no device flag touched
                  next_s.req = 1'b0;
                  next_s.done = 1'b1;
               end
            end
         end
         IAG_S_WAIT: begin
            // request stands alone on the bus until answered or abandoned
            if (bus.ack) begin
               next_s.req = 1'b0;
               next_s.busy = 1'b0;
               next_s.done = 1'b1;
               next_s.skip = bus.cond;
               // one-byte reads are masked again here, so a careless controller
               // can never leak a stale upper byte into the accumulator
               if (iag_is_input(s.io_func)) begin
                  next_s.acc_out = s.two_byte ? bus.rdata : {8'h00, bus.rdata[7:0]};
               end
               next_s.state = IAG_S_IDLE;
            end else if (s.tcount == TCNT_W'(IO_TIMEOUT_CYC - 1)) begin
               // no controller at this code: give up rather than hang the bus
               // limitation: a controller answering later than this is ignored,
               // its late ack falls on an idle sequencer and is dropped
               next_s.req = 1'b0;
               next_s.busy = 1'b0;
               next_s.done = 1'b1;
               next_s.timeout = 1'b1;
               next_s.state = IAG_S_IDLE;
            end else begin
               next_s.tcount = s.tcount + TCNT_W'(1);
            end
         end
         // an illegal state code returns to idle and drops the request
         default: begin
            next_s.state = IAG_S_IDLE;
            next_s.req = 1'b0;
            next_s.busy = 1'b0;
         end
      endcase
   end

   // whole state in one register; ce low freezes everything
   // reset leaves the sequencer idle with a none verdict, so the first
   // issue right after release is taken at once
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s <= '0;
         s.state <= IAG_S_IDLE;
         s.verdict <= IAG_V_NONE;
      end else if (ce) begin
         s <= next_s;
      end
   end

   // all outputs straight from the state register
   // registered outputs cost a cycle of latency but keep the bus glitch free
   assign bus.req = s.req;
   assign bus.out_dir = s.out_dir;
   assign bus.dev_code = s.dev_code;
   assign bus.io_func = s.io_func;
   assign bus.flag_ctl = s.flag_ctl;
   assign bus.two_byte = s.two_byte;
   assign bus.wdata = s.wdata;
   assign busy = s.busy;
   assign done = s.done;
   assign verdict = s.verdict;
   assign fault = s.fault;
   assign acc_out = s.acc_out;
   assign skip = s.skip;
   assign timeout = s.timeout;
endmodule // iag_cpu_end
`default_nettype wire

// ---- bench/iag_io_checker.sv ----
/*
 iag_io_checker: timing checks on the programmed i/o bus.
 assumes: placed beside the interface; one clock, async high reset.
*/
`timescale 1ns/100ps
`default_nettype none
module iag_io_checker #(
   parameter logic [5:0] MY_CODE = 6'h10
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic req,
   input wire logic out_dir,
   input wire logic [5:0] dev_code,
   input wire logic [2:0] io_func,
   input wire logic two_byte,
   input wire logic [15:0] wdata,
   input wire logic ack
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // a request to our code opens, then ack and release close it
   sequence s_open;
      !req ##1 req && dev_code == MY_CODE;
   endsequence
   sequence s_close;
      ack ##1 !req;
   endsequence
   a_hit_gets_ack: assert property (s_open |=> s_close)
      else $error("own code request not answered in one cycle");
   a_req_qual_stable: assert property (req ##1 req |->
      $stable(dev_code) && $stable(io_func) && $stable(out_dir) && $stable(wdata))
      else $error("request qualifiers moved while pending");
   a_ack_one_cycle: assert property (ack |=> !ack)
      else $error("ack longer than one cycle");
   a_req_drop_ack: assert property (ack |=> !req)
      else $error("req held after ack");
   a_ack_own_code: assert property (ack |-> $past(req) && $past(dev_code) == MY_CODE)
      else $error("ack without own code request");
   a_foreign_quiet: assert property (req && dev_code != MY_CODE |=> !ack)
      else $error("ack to foreign code");
   a_wait_bounded: assert property ($rose(req) |-> ##[1:60] !req)
      else $error("request never released");
   a_byte_upper: assert property (req && out_dir && !two_byte |-> wdata[15:8] == 8'h00)
      else $error("upper byte not zero in one byte mode");
   a_dir_named: assert property (req |-> out_dir == (io_func inside {3'h2, 3'h4, 3'h6}))
      else $error("direction does not match opcode");
endmodule // iag_io_checker
`default_nettype wire

// ---- bench/io_access_gate_tb_top.sv ----
/*
 io_access_gate_tb_top: both bus ends joined, scenarios per task.
 assumes: 25 MHz clock; device end answers code 6'h10 only.
*/
`timescale 1ns/100ps
`default_nettype none
module io_access_gate_tb_top;
   import iag_pkg::*;
   logic clk, rst, ce, issue, is_lea_op, is_ext_lea_op, xlat_en, two_byte, finish;
   logic [15:0] instr, acc_in, in_a, in_b, in_c, acc_out, buf_a, buf_b, buf_c;
   logic [31:0] seg_base;
   logic c_busy, c_done, fault, skip, timeout, d_busy, d_done, start, special;
   logic saw_req, saw_to, saw_start, saw_special, saw_busy, m_xl, m_tb;
   logic [31:0] m_sb;
   logic [15:0] m_acc;
   iag_verdict_t verdict;
   int miscompares = 0;
   int checks_done = 0;
   iag_io_if io ();
   iag_cpu_end u_iag_cpu_end (.clk(clk), .rst(rst), .ce(ce), .issue(issue), .instr(instr),
      .is_lea_op(is_lea_op), .is_ext_lea_op(is_ext_lea_op), .xlat_en(xlat_en),
      .seg_base(seg_base), .acc_in(acc_in), .two_byte(two_byte), .bus(io.cpu), .busy(c_busy),
      .done(c_done), .verdict(verdict), .fault(fault), .acc_out(acc_out), .skip(skip),
      .timeout(timeout));
   iag_dev_end #(.MY_CODE(6'h10)) u_iag_dev_end (.clk(clk), .rst(rst), .ce(ce), .bus(io.dev),
      .in_a(in_a), .in_b(in_b), .in_c(in_c), .finish(finish), .buf_a(buf_a), .buf_b(buf_b),
      .buf_c(buf_c), .busy(d_busy), .done(d_done), .start(start), .special(special));
   iag_io_checker #(.MY_CODE(6'h10)) u_iag_io_checker (.clk(clk), .rst(rst), .req(io.req),
      .out_dir(io.out_dir), .dev_code(io.dev_code), .io_func(io.io_func),
      .two_byte(io.two_byte), .wdata(io.wdata), .ack(io.ack));
   // 40 ns clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic summarize();
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: word %h want %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      chk_word({15'h0000, got}, {15'h0000, exp});
   endtask
   task automatic chk_verdict(input iag_verdict_t exp);
      chk_word({13'h0000, verdict}, {13'h0000, exp});
   endtask
   function automatic logic [15:0] mk(input logic [2:0] opc, input logic [1:0] fl,
         input logic [5:0] dev);
      return {IO_PATTERN, 2'h0, opc, fl, dev};
   endfunction
   // issue one instruction and watch the bus until done, bounded wait
   task automatic run(input logic [15:0] ins, input logic lea, input logic ext);
      int n;
      @(posedge clk);
      instr <= ins;
      is_lea_op <= lea;
      is_ext_lea_op <= ext;
      xlat_en <= m_xl;
      seg_base <= m_sb;
      acc_in <= m_acc;
      two_byte <= m_tb;
      issue <= 1'b1;
      {saw_req, saw_to, saw_start, saw_special, saw_busy} = 5'h00;
      @(posedge clk);
      issue <= 1'b0;
      // a non-i/o done stands right after the taking edge, so look before waiting
      for (n = 0; n < 80; n++) begin
         #1;
         saw_req |= io.req;
         saw_to |= timeout;
         saw_start |= start;
         saw_special |= special;
         saw_busy |= c_busy;
         if (c_done === 1'b1) begin
            break;
         end
         @(posedge clk);
      end
      chk_bit(c_done, 1'b1);
   endtask
   // translation off: base ignored though it denies i/o
   task automatic t_phys();
      {m_xl, m_sb, m_acc, m_tb} = {1'b0, 32'h0000_0000, 16'hBEEF, 1'b1};
      run(mk(OPC_OUT_A, FLAG_NONE, 6'h10), 1'b0, 1'b0);
      chk_verdict(IAG_V_IO_EXEC);
      chk_word(buf_a, 16'hBEEF);
      chk_bit(saw_busy, 1'b1);
   endtask
   // address-load mode and protection cases, none may touch the bus
   task automatic t_modes();
      {m_xl, m_sb} = {1'b1, 32'h3000_0000};
      run(mk(OPC_OUT_B, FLAG_NONE, 6'h10), 1'b0, 1'b0);
      chk_verdict(IAG_V_LEA);
      chk_bit(saw_req, 1'b0);
      run(16'h0000, 1'b1, 1'b0);
      chk_verdict(IAG_V_LEA);
      run(16'h0000, 1'b0, 1'b1);
      chk_verdict(IAG_V_EXT_LEA);
      m_sb = 32'h0000_0000;
      run(16'h0000, 1'b0, 1'b1);
      chk_verdict(IAG_V_EXT_LEA);
      run(mk(OPC_OUT_B, FLAG_START, 6'h10), 1'b0, 1'b0);
      chk_verdict(IAG_V_PROT_FAULT);
      chk_bit(fault, 1'b1);
      chk_bit(saw_req | saw_start | saw_busy, 1'b0);
      run(16'h0000, 1'b1, 1'b0);
      chk_verdict(IAG_V_PROT_FAULT);
   endtask
   // one byte transfers through every buffer, both directions
   task automatic t_data();
      logic [2:0] outs[3] = '{OPC_OUT_A, OPC_OUT_B, OPC_OUT_C};
      logic [2:0] ins[3] = '{OPC_IN_A, OPC_IN_B, OPC_IN_C};
      logic [15:0] exp_in[3] = '{16'h00A1, 16'h00B2, 16'h00C3};
      {m_sb, m_tb} = {32'h1000_0000, 1'b0};
      // an address-load opcode in valid i/o mode runs as a flag-only transfer
      run(16'h0010, 1'b1, 1'b0);
      chk_verdict(IAG_V_IO_EXEC);
      chk_bit(saw_req, 1'b1);
      for (int k = 0; k < 3; k++) begin
         m_acc = {8'hE0, 8'(k + 1)};
         run(mk(outs[k], FLAG_NONE, 6'h10), 1'b0, 1'b0);
         chk_verdict(IAG_V_IO_EXEC);
         chk_word(k == 0 ? buf_a : k == 1 ? buf_b : buf_c, {8'h00, 8'(k + 1)});
         run(mk(ins[k], FLAG_NONE, 6'h10), 1'b0, 1'b0);
         chk_word(acc_out, exp_in[k]);
      end
   endtask
   // device flags set, tested and cleared over the bus, finished by the controller input
   task automatic t_flags();
      run(mk(OPC_NO_XFER, FLAG_START, 6'h10), 1'b0, 1'b0);
      chk_bit(saw_start & d_busy & ~d_done, 1'b1);
      run(mk(OPC_SKIP, TEST_BUSY_SET, 6'h10), 1'b0, 1'b0);
      chk_bit(skip, 1'b1);
      run(mk(OPC_SKIP, TEST_DONE_SET, 6'h10), 1'b0, 1'b0);
      chk_bit(skip, 1'b0);
      @(posedge clk);
      finish <= 1'b1;
      @(posedge clk);
      finish <= 1'b0;
      run(mk(OPC_SKIP, TEST_BUSY_ZERO, 6'h10), 1'b0, 1'b0);
      chk_bit(skip & d_done, 1'b1);
      run(mk(OPC_NO_XFER, FLAG_PULSE, 6'h10), 1'b0, 1'b0);
      chk_bit(saw_special, 1'b1);
      run(mk(OPC_NO_XFER, FLAG_CLEAR, 6'h10), 1'b0, 1'b0);
      chk_bit(d_done, 1'b0);
      run(mk(OPC_SKIP, TEST_DONE_ZERO, 6'h10), 1'b0, 1'b0);
      chk_bit(skip, 1'b1);
      chk_bit(d_busy, 1'b0);
   endtask
   // wrong pattern is no i/o; unanswered code times out
   task automatic t_decode();
      run(16'h4010, 1'b0, 1'b0);
      chk_verdict(IAG_V_NONE);
      chk_bit(saw_req, 1'b0);
      run(mk(OPC_OUT_A, FLAG_NONE, 6'h11), 1'b0, 1'b0);
      chk_bit(saw_to & saw_req, 1'b1);
   endtask
   // ce low freezes both ends: an issue presented then is never taken
   task automatic t_hold();
      @(posedge clk);
      ce <= 1'b0;
      instr <= mk(OPC_OUT_A, FLAG_NONE, 6'h10);
      issue <= 1'b1;
      for (int k = 0; k < 3; k++) begin
         @(posedge clk);
         #1;
         chk_bit(c_done | c_busy | io.req, 1'b0);
      end
      @(posedge clk);
      issue <= 1'b0;
      ce <= 1'b1;
      @(posedge clk);
      #1;
      chk_bit(c_done | c_busy | io.req, 1'b0);
   endtask
   // reset, then the scenarios
   initial begin
      {rst, ce, issue, is_lea_op, is_ext_lea_op, xlat_en, two_byte, finish} = 8'hC0;
      {instr, acc_in, seg_base} = 64'h0;
      {in_a, in_b, in_c} = {16'h55A1, 16'h55B2, 16'h55C3};
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      t_phys();
      t_modes();
      t_data();
      t_flags();
      t_decode();
      t_hold();
      summarize();
   end
   // hang guard, well above the 150 or so cycles the run needs
   initial begin
      #(40 * 6000);
      miscompares++;
      summarize();
   end
endmodule // io_access_gate_tb_top
`default_nettype wire
